// File: include/i2csf_pkg.sv
/*
 * constants for the i2c status-flag block: register offsets, status bit
 * positions, reset values and the bus response codes.
 * assumes a 32-bit axi4-lite register bus and a 20 mhz block clock.
 */
// Summary of operation
// - flag missing slave ack at ack end
// - tx-active flag spans eight bits plus ack
// - collision flag clears only on re-enable
// - general call flag set on match, stop clears
// - ten-bit flag set on second byte match
// - tx write while busy: flag, drop write
// - receive into full buffer sets overflow flag
// - data/address flag tracks last received byte
// - unimplemented status bits read zero, ignore writes
`default_nettype none
package i2csf_pkg;
    // register byte offsets
    localparam logic [3:0] I2CSF_OFS_STATUS = 4'h0;
    localparam logic [3:0] I2CSF_OFS_CTRL = 4'h4;
    localparam logic [3:0] I2CSF_OFS_TXDATA = 4'h8;
    localparam logic [3:0] I2CSF_OFS_RXDATA = 4'hC;
    // status bit positions and the control enable bit
    localparam int I2CSF_B_ACKNR = 15;
    localparam int I2CSF_B_MTXACT = 14;
    localparam int I2CSF_B_BCOL = 10;
    localparam int I2CSF_B_GCALL = 9;
    localparam int I2CSF_B_TENB = 8;
    localparam int I2CSF_B_WCOL = 7;
    localparam int I2CSF_B_RXOV = 6;
    localparam int I2CSF_B_DATA = 5;
    localparam int I2CSF_B_STOP = 4;
    localparam int I2CSF_B_START = 3;
    localparam int I2CSF_B_READ = 2;
    localparam int I2CSF_B_RXFULL = 1;
    localparam int I2CSF_B_TXFULL = 0;
    localparam int I2CSF_B_ON = 15;
    // reset values
    localparam logic [15:0] I2CSF_STATUS_RST = 16'h0000;
    localparam logic [7:0] I2CSF_BYTE_RST = 8'h00;
    localparam logic I2CSF_ON_RST = 1'b0;
    // axi responses
    localparam logic [1:0] I2CSF_RESP_OKAY = 2'b00;
    localparam logic [1:0] I2CSF_RESP_SLVERR = 2'b10;
endpackage : i2csf_pkg
`default_nettype wire

// File: rtl/i2csf_status.sv
/*
 * status-flag logic of a two-wire serial controller with its axi4-lite
 * register slave (status, control, tx data, rx data).
 * assumes the controller core gives one-cycle event pulses on aclk and
 * that scl/sda arrive raw from the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module i2csf_status
    import i2csf_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic core_busy_i,
    input wire logic mtx_start_i,
    input wire logic slave_ack_done_i,
    input wire logic slave_nack_i,
    input wire logic collision_i,
    input wire logic gcall_match_i,
    input wire logic ten_bit_match_i,
    input wire logic addr_match_i,
    input wire logic addr_rw_i,
    input wire logic data_byte_i,
    input wire logic rx_xfer_i,
    input wire logic [7:0] rx_shift_reg_i,
    input wire logic tx_load_i,
    output logic enable_o,
    output logic [7:0] tx_data_reg_o,
    output logic tx_buffer_full_o
);
    // write channel holding
    logic aw_held_q, w_held_q;
    logic [3:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    // flags and registers
    logic [15:0] status_word;
    logic ack_not_received_q, master_tx_active_q, bus_collision_q, general_call_seen_q;
    logic ten_bit_matched_q, tx_write_collision_q, rx_overflow_q, data_last_q, stop_seen_q;
    logic start_seen_q, read_dir_q, rx_buffer_full_q, tx_buffer_full_q;
    logic on_q, on_prev_q;
    logic [7:0] rx_data_reg_q;
    logic [2:0] scl_s_q, sda_s_q;
    logic start_det, stop_det;
    logic wr_status, wr_tx, wr_ctrl, rd_rx;
    logic tx_busy;

    // both channels accepted independently, response after both
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            waddr_q <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= I2CSF_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (waddr_q[1:0] == 2'b00) ? I2CSF_RESP_OKAY : I2CSF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // decoded write strobes and the rx data read strobe, used by the register and flag processes
    assign wr_status = wr_go && waddr_q == I2CSF_OFS_STATUS && wstrb_q[0];
    assign wr_ctrl = wr_go && waddr_q == I2CSF_OFS_CTRL && wstrb_q[1];
    assign wr_tx = wr_go && waddr_q == I2CSF_OFS_TXDATA && wstrb_q[0];
    assign rd_rx = s_axi_arvalid && s_axi_arready && s_axi_araddr == I2CSF_OFS_RXDATA;

    // read data registered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= I2CSF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= I2CSF_RESP_OKAY;
            unique case (s_axi_araddr)
                I2CSF_OFS_STATUS: s_axi_rdata <= {16'h0000, status_word};
                I2CSF_OFS_CTRL: s_axi_rdata <= {16'h0000, on_q, 15'h0000};
                I2CSF_OFS_TXDATA: s_axi_rdata <= {24'h00_0000, tx_data_reg_o};
                I2CSF_OFS_RXDATA: s_axi_rdata <= {24'h00_0000, rx_data_reg_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= I2CSF_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // module enable; previous value kept to see the re-enable edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_q <= I2CSF_ON_RST;
            on_prev_q <= I2CSF_ON_RST;
        end else begin
            on_prev_q <= on_q;
            if (wr_ctrl) begin
                on_q <= wdata_q[I2CSF_B_ON];
            end
        end
    end
    assign enable_o = on_q;

    // pin synchronisers; stage 0 is read only by stage 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_s_q <= 3'b111;
            sda_s_q <= 3'b111;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
        end
    end
    // sda edge while scl high marks start or stop
    assign start_det = scl_s_q[1] && scl_s_q[2] && sda_s_q[2] && !sda_s_q[1];
    assign stop_det = scl_s_q[1] && scl_s_q[2] && !sda_s_q[2] && sda_s_q[1];

    assign tx_busy = core_busy_i || master_tx_active_q || tx_buffer_full_q;
    // master transmit progress and acknowledge result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_not_received_q <= 1'b0;
            master_tx_active_q <= 1'b0;
        end else begin
            if (slave_ack_done_i) ack_not_received_q <= slave_nack_i;
            if (mtx_start_i) master_tx_active_q <= 1'b1;
            else if (slave_ack_done_i) master_tx_active_q <= 1'b0;
        end
    end
    // collision: only an off-to-on edge of the enable clears it
    always_ff @(posedge aclk) begin
        if (!aresetn) bus_collision_q <= 1'b0;
        else if (collision_i) bus_collision_q <= 1'b1;
        else if (on_q && !on_prev_q) bus_collision_q <= 1'b0;
    end
    // address match flags cleared at stop; a new match wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            general_call_seen_q <= 1'b0;
            ten_bit_matched_q <= 1'b0;
        end else begin
            if (gcall_match_i) general_call_seen_q <= 1'b1;
            else if (stop_det) general_call_seen_q <= 1'b0;
            if (ten_bit_match_i) ten_bit_matched_q <= 1'b1;
            else if (stop_det) ten_bit_matched_q <= 1'b0;
        end
    end
    // software-clearable flags: writing 0 clears, hardware set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_write_collision_q <= 1'b0;
            rx_overflow_q <= 1'b0;
        end else begin
            if (wr_tx && tx_busy) tx_write_collision_q <= 1'b1;
            else if (wr_status && !wdata_q[I2CSF_B_WCOL]) tx_write_collision_q <= 1'b0;
            if (rx_xfer_i && rx_buffer_full_q && !rd_rx) rx_overflow_q <= 1'b1;
            else if (wr_status && !wdata_q[I2CSF_B_RXOV]) rx_overflow_q <= 1'b0;
        end
    end
    // slave byte type and direction of the last address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_last_q <= 1'b0;
            read_dir_q <= 1'b0;
        end else if (addr_match_i) begin
            data_last_q <= 1'b0;
            read_dir_q <= addr_rw_i;
        end else if (data_byte_i) begin
            data_last_q <= 1'b1;
        end
    end
    // start and stop flags; each clears the other, software may clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_seen_q <= 1'b0;
            start_seen_q <= 1'b0;
        end else begin
            if (stop_det) stop_seen_q <= 1'b1;
            else if (start_det || (wr_status && !wdata_q[I2CSF_B_STOP])) stop_seen_q <= 1'b0;
            if (start_det) start_seen_q <= 1'b1;
            else if (stop_det || (wr_status && !wdata_q[I2CSF_B_START])) start_seen_q <= 1'b0;
        end
    end
    // receive buffer: overflow keeps the unread byte, read empties it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buffer_full_q <= 1'b0;
            rx_data_reg_q <= I2CSF_BYTE_RST;
        end else if (rx_xfer_i && (!rx_buffer_full_q || rd_rx)) begin
            rx_buffer_full_q <= 1'b1;
            rx_data_reg_q <= rx_shift_reg_i;
        end else if (rd_rx) begin
            rx_buffer_full_q <= 1'b0;
        end
    end
    // transmit register: a write while busy is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buffer_full_q <= 1'b0;
            tx_data_reg_o <= I2CSF_BYTE_RST;
        end else if (wr_tx && !tx_busy) begin
            tx_buffer_full_q <= 1'b1;
            tx_data_reg_o <= wdata_q[7:0];
        end else if (tx_load_i) begin
            tx_buffer_full_q <= 1'b0;
        end
    end
    assign tx_buffer_full_o = tx_buffer_full_q;
    // status word in bit order; one driver per flag keeps lint quiet
    assign status_word = {ack_not_received_q, master_tx_active_q, 3'b000,
        bus_collision_q, general_call_seen_q, ten_bit_matched_q, tx_write_collision_q,
        rx_overflow_q, data_last_q, stop_seen_q, start_seen_q, read_dir_q,
        rx_buffer_full_q, tx_buffer_full_q};

    // checks
    a_ack_update: assert property (@(posedge aclk) disable iff (!aresetn)
        slave_ack_done_i |=> ack_not_received_q == $past(slave_nack_i))
        else $error("ack status not updated");
    a_mtx_span: assert property (@(posedge aclk) disable iff (!aresetn)
        mtx_start_i ##1 !slave_ack_done_i[*2] |-> master_tx_active_q)
        else $error("tx active dropped early");
    a_bcol_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        bus_collision_q && !(on_q && !on_prev_q) |=> bus_collision_q)
        else $error("collision flag cleared");
    a_gcall_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_det && !gcall_match_i |=> !general_call_seen_q)
        else $error("general call not cleared at stop");
    a_tenb_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ten_bit_match_i |=> ten_bit_matched_q)
        else $error("ten-bit flag not set");
    a_wcol_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_tx && tx_busy |=> tx_write_collision_q && $stable(tx_data_reg_o))
        else $error("busy write not dropped");
    a_rxov_set: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_xfer_i && rx_buffer_full_q && !rd_rx |=> rx_overflow_q && $stable(rx_data_reg_q))
        else $error("overflow not flagged");
    a_da_track: assert property (@(posedge aclk) disable iff (!aresetn)
        addr_match_i |=> !data_last_q)
        else $error("address match left data flag");
    a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_axi_rvalid) && $past(s_axi_araddr) == I2CSF_OFS_STATUS
        |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[13:11] == 3'b000)
        else $error("unimplemented bits nonzero");
    a_start_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        start_det |=> start_seen_q && !stop_seen_q)
        else $error("start flag wrong");
    a_tbf_set: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_tx && !tx_busy |=> tx_buffer_full_q)
        else $error("tx buffer full not set");
    c_nack: cover property (@(posedge aclk) slave_ack_done_i && slave_nack_i);
    c_overflow: cover property (@(posedge aclk) $rose(rx_overflow_q));
    c_wcol: cover property (@(posedge aclk) $rose(tx_write_collision_q));
    c_stop: cover property (@(posedge aclk) stop_det ##1 stop_seen_q);
endmodule // i2csf_status
`default_nettype wire

// File: tb/i2csf_bus_model.sv
/*
 * behavioural far side of the two-wire bus: another master that frames
 * start and stop conditions on scl and sda.
 * assumes open-drain lines with pull-ups, so both idle high between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module i2csf_bus_model (
    output logic scl,
    output logic sda
);
    // released lines float to the pull-up level
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // data falls while clock high; 7 ns offset keeps edges off aclk
    task automatic send_start();
        #7;
        sda = 1'b1;
        scl = 1'b1;
        #200;
        sda = 1'b0;
        #200;
        scl = 1'b0;
        #200;
    endtask

    // data rises while clock high; clock then stands still high
    task automatic send_stop();
        #7;
        sda = 1'b0;
        #200;
        scl = 1'b1;
        #200;
        sda = 1'b1;
        #200;
    endtask
endmodule // i2csf_bus_model
`default_nettype wire

// File: tb/test_i2c_status_flags.sv
/*
 * self-checking bench for the status-flag block: axi4-lite register
 * tasks, core event pulses and bus framing from the bus model.
 * assumes the package is compiled first and the bus model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module test_i2c_status_flags
    import i2csf_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    wire scl_i, sda_i;
    logic [8:0] ev = 9'h000; // one-cycle core events
    logic [2:0] lv = 3'h0; // busy, no-ack, direction levels
    logic [7:0] rxb = 8'h00;
    logic enable_o, tx_buffer_full_o;
    logic [7:0] tx_data_reg_o;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] d;

    always #25 aclk = ~aclk;

    i2csf_status i_i2csf_status (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .scl_i, .sda_i, .core_busy_i(lv[0]), .mtx_start_i(ev[0]),
        .slave_ack_done_i(ev[1]), .slave_nack_i(lv[1]), .collision_i(ev[2]),
        .gcall_match_i(ev[3]), .ten_bit_match_i(ev[4]), .addr_match_i(ev[5]),
        .addr_rw_i(lv[2]), .data_byte_i(ev[6]), .rx_xfer_i(ev[7]),
        .rx_shift_reg_i(rxb), .tx_load_i(ev[8]), .enable_o, .tx_data_reg_o,
        .tx_buffer_full_o
    );

    i2csf_bus_model i_i2csf_bus_model (
        .scl(scl_i),
        .sda(sda_i)
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ad, wd;
        int n;
        ad = 1'b0;
        wd = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd) && n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        if (n >= 40) mismatches++;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] v);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 40);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        if (n >= 40) mismatches++;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // one status bit read back through the bus
    task automatic st(input string nm, input int b, input logic e);
        logic [31:0] v;
        rd(I2CSF_OFS_STATUS, I2CSF_RESP_OKAY, v);
        chk(nm, {31'h0, e}, {31'h0, v[b]});
    endtask

    task automatic pulse(input int k);
        @(posedge aclk);
        ev[k] <= 1'b1;
        @(posedge aclk);
        ev[k] <= 1'b0;
    endtask

    task automatic setlv(input logic [2:0] l, input logic [7:0] b);
        @(posedge aclk);
        lv <= l;
        rxb <= b;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hang counts as a mismatch; the run needs well under 2000 cycles
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(I2CSF_OFS_STATUS, I2CSF_RESP_OKAY, d);
        chk("status_rst", 32'h0000_0000, d);
        wr(I2CSF_OFS_CTRL, 32'h0000_8000, I2CSF_RESP_OKAY);
        chk("enable", 32'h0000_0001, {31'h0, enable_o});
        // master byte not acknowledged, then one acknowledged
        setlv(3'b010, 8'h00);
        pulse(0);
        st("tx_active_set", I2CSF_B_MTXACT, 1'b1);
        pulse(1);
        st("nack_set", I2CSF_B_ACKNR, 1'b1);
        st("tx_active_clr", I2CSF_B_MTXACT, 1'b0);
        setlv(3'b000, 8'h00);
        pulse(0);
        pulse(1);
        st("nack_clr", I2CSF_B_ACKNR, 1'b0);
        // collision survives writes and a plain disable
        pulse(2);
        wr(I2CSF_OFS_STATUS, 32'h0000_0000, I2CSF_RESP_OKAY);
        st("bcol_write", I2CSF_B_BCOL, 1'b1);
        wr(I2CSF_OFS_CTRL, 32'h0000_0000, I2CSF_RESP_OKAY);
        st("bcol_off", I2CSF_B_BCOL, 1'b1);
        wr(I2CSF_OFS_CTRL, 32'h0000_8000, I2CSF_RESP_OKAY);
        st("bcol_reenable", I2CSF_B_BCOL, 1'b0);
        // address matches held until the bus stop
        pulse(3);
        pulse(4);
        i_i2csf_bus_model.send_start();
        st("gcall_set", I2CSF_B_GCALL, 1'b1);
        st("tenb_set", I2CSF_B_TENB, 1'b1);
        st("start_set", I2CSF_B_START, 1'b1);
        i_i2csf_bus_model.send_stop();
        st("gcall_clr", I2CSF_B_GCALL, 1'b0);
        st("tenb_clr", I2CSF_B_TENB, 1'b0);
        st("stop_set", I2CSF_B_STOP, 1'b1);
        st("start_clr", I2CSF_B_START, 1'b0);
        // slave address with read direction, then a data byte
        setlv(3'b100, 8'h00);
        pulse(5);
        st("addr_last", I2CSF_B_DATA, 1'b0);
        st("dir_read", I2CSF_B_READ, 1'b1);
        pulse(6);
        st("data_last", I2CSF_B_DATA, 1'b1);
        // tx writes while the core is busy or the buffer is full are dropped
        setlv(3'b001, 8'h00);
        wr(I2CSF_OFS_TXDATA, 32'h0000_005A, I2CSF_RESP_OKAY);
        st("wcol_busy", I2CSF_B_WCOL, 1'b1);
        chk("txd_drop", 32'h0000_0000, {24'h0, tx_data_reg_o});
        wr(I2CSF_OFS_STATUS, 32'h0000_0000, I2CSF_RESP_OKAY);
        st("wcol_clr", I2CSF_B_WCOL, 1'b0);
        setlv(3'b000, 8'h00);
        wr(I2CSF_OFS_TXDATA, 32'h0000_00A5, I2CSF_RESP_OKAY);
        chk("txd_load", 32'h0000_00A5, {24'h0, tx_data_reg_o});
        st("txfull_set", I2CSF_B_TXFULL, 1'b1);
        chk("txfull_pin_set", 32'h0000_0001, {31'h0, tx_buffer_full_o});
        wr(I2CSF_OFS_TXDATA, 32'h0000_003C, I2CSF_RESP_OKAY);
        st("wcol_full", I2CSF_B_WCOL, 1'b1);
        chk("txd_keep", 32'h0000_00A5, {24'h0, tx_data_reg_o});
        pulse(8);
        st("txfull_clr", I2CSF_B_TXFULL, 1'b0);
        chk("txfull_pin", 32'h0000_0000, {31'h0, tx_buffer_full_o});
        // second byte arrives before the first is read
        setlv(3'b000, 8'h3C);
        pulse(7);
        st("rxfull_set", I2CSF_B_RXFULL, 1'b1);
        setlv(3'b000, 8'h99);
        pulse(7);
        st("ov_set", I2CSF_B_RXOV, 1'b1);
        rd(I2CSF_OFS_RXDATA, I2CSF_RESP_OKAY, d);
        chk("rx_old", 32'h0000_003C, d);
        st("rxfull_clr", I2CSF_B_RXFULL, 1'b0);
        wr(I2CSF_OFS_STATUS, 32'h0000_0000, I2CSF_RESP_OKAY);
        st("ov_clr", I2CSF_B_RXOV, 1'b0);
        // unimplemented positions ignore ones and read zero
        wr(I2CSF_OFS_STATUS, 32'hFFFF_FFFF, I2CSF_RESP_OKAY);
        rd(I2CSF_OFS_STATUS, I2CSF_RESP_OKAY, d);
        chk("unimpl", 32'h0000_0000, d & 32'hFFFF_3800);
        // unaligned address is refused on both paths
        wr(4'h2, 32'h0000_0000, I2CSF_RESP_SLVERR);
        rd(4'h2, I2CSF_RESP_SLVERR, d);
        tally_and_finish();
    end
endmodule // test_i2c_status_flags
`default_nettype wire
